// File: logic/pin_function_resource_router.sv
// Digital pin data, direction, function select and resource routing
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Direction bit clear makes the pin input, set makes it output.
// - Pins 24 to 55 take direction from cell bit 3; 36 to 55 data from bit 0.
// - Pins 56 to 58 use own bytes: direction bit 7, data bit 4.
// - One function map bit per multi-use pin picks general I/O or LCD.
// - Pins 24 to 55 share storage with their LCD segment cells.
// - Segment cells follow the I/O RAM map; pin 43 data at 0x2045 bit 4.
// - Odd segment cells sit in bits 7 to 4 of their byte.
// - Pins 6 and 7 carry energy pulses when outputs with enable set.
// - Pins 8 and 9 can carry the auxiliary X and Y pulses.
// - The push-button pin is always an input.
// - With optical UART unused its pins act as general pins 1 and 2.
// - Eligible general pins have a 3-bit selector, active even as outputs.
// - Serial receive pin has its own selector with the same codes.
// - Code 0 none, 1 reserved, 2 counter 0 clock, 3 counter 1 clock.
// - Codes 4,5 rising edge high/low irq; 6,7 falling edge.
// - Several pins on one resource are ORed together.
// - Pins 4 and 5 may be handed to the EEPROM serial interface.
// - Pin data from port registers at 0x80, 0x90, 0xA0, 0xB0.
module pin_function_resource_router
  import pin_router_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Pads
  input wire logic [NUM_PINS-1:0] i_pin_in,
  output logic [NUM_PINS-1:0] o_pin_out,
  output logic [NUM_PINS-1:0] o_pin_oe,
  output logic [NUM_PINS-1:0] o_pin_lcd_sel,
  // SFR access port
  input wire logic i_sfr_we,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // I/O RAM access port
  input wire logic i_ioram_we,
  input wire logic [15:0] i_ioram_addr,
  input wire logic [7:0] i_ioram_wdata,
  output logic [7:0] o_ioram_rdata,
  // Function select and pulse routing controls
  input wire logic [NUM_SEG-1:0] i_pin_function_map,
  input wire logic i_active_pulse_route_en,
  input wire logic i_reactive_pulse_route_en,
  input wire logic i_aux_x_route_en,
  input wire logic i_aux_y_route_en,
  input wire logic i_optical_uart_en,
  input wire logic i_eeprom_route_en,
  // Compute engine pulses
  input wire logic i_active_energy_pulse,
  input wire logic i_reactive_energy_pulse,
  input wire logic i_aux_x_pulse,
  input wire logic i_aux_y_pulse,
  // Optical UART and EEPROM engine
  input wire logic i_optical_tx_pin,
  output logic o_optical_rx_pin,
  input wire logic i_ee_sck_out,
  input wire logic i_ee_sck_oe,
  input wire logic i_ee_sda_out,
  input wire logic i_ee_sda_oe,
  output logic o_ee_sda_in,
  // Routed resources
  output logic o_counter0_clock_in,
  output logic o_counter1_clock_in,
  output logic o_high_prio_pin_irq,
  output logic o_low_prio_pin_irq
);

  localparam logic [15:0] CELL43_ADDR = SEG_BASE + 16'((43 + SEG_OFS) >> 1);
  localparam int PE_W = 4;

  function automatic logic [NIB_W-1:0] lane(input logic [7:0] b, input logic hi);
    lane = hi ? b[HI_LSB +: NIB_W] : b[NIB_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pad synchroniser; the first stage feeds only the second
  logic [NUM_PINS-1:0] pin_meta_r;
  logic [NUM_PINS-1:0] pin_sync_r;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end
    else
    begin
      pin_meta_r <= i_pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0] port_r [PORT_REGS];
  logic [7:0] dir_r [DIR_REGS];
  logic [NIB_W-1:0] seg_r [NUM_SEG];
  logic [DED_PINS-1:0] ded_dat_r;
  logic [DED_PINS-1:0] ded_dir_r;
  logic [SEL_W-1:0] rsel_r [NUM_SEL_PINS];
  logic [SEL_W-1:0] srx_sel_r;
  logic [PE_W-1:0] pulse_en_r;

  // Write decode
  logic [PORT_REGS-1:0] port_hit;
  logic [DIR_REGS-1:0] dir_hit;
  wire seg_hit = i_ioram_we && i_ioram_addr >= SEG_BASE && i_ioram_addr <= SEG_LAST;
  wire rsel_hit = i_ioram_we && i_ioram_addr >= RSEL_BASE && i_ioram_addr <= RSEL_LAST;
  wire srx_hit = i_ioram_we && i_ioram_addr == SRX_RSEL_ADDR;
  wire [15:0] seg_ofs = i_ioram_addr - SEG_BASE;
  wire [15:0] rsel_ofs = i_ioram_addr - RSEL_BASE;
  wire [15:0] ddat_ofs = i_ioram_addr - DED_DATA_BASE;
  wire [15:0] ddir_ofs = i_ioram_addr - DED_DIR_BASE;
  wire [5:0] seg_byte = seg_ofs[5:0];
  wire [2:0] rsel_byte = rsel_ofs[2:0];

  for (genvar g = 0; g < PORT_REGS; g++)
  begin : g_port_hit
    assign port_hit[g] = i_sfr_we && i_sfr_addr == SFR_PORT_ADDR[g];
  end
  for (genvar g = 0; g < DIR_REGS; g++)
  begin : g_dir_hit
    assign dir_hit[g] = i_sfr_we && i_sfr_addr == SFR_DIR_ADDR[g];
  end

  always_ff @(posedge i_clk)
  begin
    for (int k = 0; k < PORT_REGS; k++)
    begin
      if (i_sys_rst)
        port_r[k] <= '0;
      else if (port_hit[k])
        port_r[k] <= i_sfr_wdata;
    end
    for (int k = 0; k < DIR_REGS; k++)
    begin
      if (i_sys_rst)
        dir_r[k] <= '0;
      else if (dir_hit[k])
        dir_r[k] <= i_sfr_wdata;
    end
  end

  // Segment cells double as pin control; two cells per byte
  always_ff @(posedge i_clk)
  begin
    for (int k = 0; k < NUM_SEG; k++)
    begin
      if (i_sys_rst)
        seg_r[k] <= '0;
      else if (seg_hit && seg_byte == 6'(k >> 1))
        seg_r[k] <= lane(i_ioram_wdata, k[0]);
    end
  end

  always_ff @(posedge i_clk)
  begin
    for (int k = 0; k < NUM_SEL_PINS; k++)
    begin
      if (i_sys_rst)
        rsel_r[k] <= '0;
      else if (rsel_hit && rsel_byte == 3'(k >> 1))
        rsel_r[k] <= SEL_W'(lane(i_ioram_wdata, k[0]));
    end
    if (i_sys_rst)
      srx_sel_r <= '0;
    else if (srx_hit)
      srx_sel_r <= i_ioram_wdata[SEL_W-1:0];
  end

  always_ff @(posedge i_clk)
  begin
    for (int k = 0; k < DED_PINS; k++)
    begin
      if (i_sys_rst)
      begin
        ded_dat_r[k] <= 1'b0;
        ded_dir_r[k] <= 1'b0;
      end
      else if (i_ioram_we && ddat_ofs == 16'(k))
        ded_dat_r[k] <= i_ioram_wdata[DED_DATA_BIT];
      else if (i_ioram_we && ddir_ofs == 16'(k))
        ded_dir_r[k] <= i_ioram_wdata[DED_DIR_BIT];
    end
  end

  // Enables pass a flop so reset leaves every pulse route off
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      pulse_en_r <= '0;
    else
      pulse_en_r <= {i_aux_y_route_en, i_aux_x_route_en,
                     i_reactive_pulse_route_en, i_active_pulse_route_en};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-pin direction, data and function
  logic [NUM_PINS-1:0] pin_dir;
  logic [NUM_PINS-1:0] pin_dat;
  logic [NUM_PINS-1:0] pin_lcd;

  always_comb
  begin
    for (int p = 0; p < NUM_PINS; p++)
    begin
      pin_dir[p] = 1'b0;
      pin_dat[p] = 1'b0;
      pin_lcd[p] = 1'b0;
      if (p < SFR_DIR_PINS)
        pin_dir[p] = dir_r[p / 8][p % 8];
      else if (p < DED_FIRST)
        pin_dir[p] = seg_r[p + SEG_OFS][CELL_DIR_BIT];
      else
        pin_dir[p] = ded_dir_r[p - DED_FIRST];
      if (p < SFR_DATA_PINS)
        pin_dat[p] = port_r[p / 8][p % 8];
      else if (p >= CELL_DATA_FIRST && p < DED_FIRST)
        pin_dat[p] = seg_r[p + SEG_OFS][CELL_DATA_BIT];
      else if (p >= DED_FIRST)
        pin_dat[p] = ded_dat_r[p - DED_FIRST];
      if (p >= MULTI_FIRST && p < DED_FIRST)
        pin_lcd[p] = i_pin_function_map[p + SEG_OFS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pad drive with alternate functions layered on top
  logic [NUM_PINS-1:0] out_nxt;
  logic [NUM_PINS-1:0] oe_nxt;
  logic [NUM_PINS-1:0] out_r;
  logic [NUM_PINS-1:0] oe_r;
  logic [NUM_PINS-1:0] lcd_r;
  logic rx_r;
  logic sda_r;

  always_comb
  begin
    out_nxt = pin_dat;
    oe_nxt = pin_dir & ~pin_lcd;
    oe_nxt[PIN_BUTTON] = 1'b0;
    if (pulse_en_r[0] && oe_nxt[PIN_ACT])
      out_nxt[PIN_ACT] = i_active_energy_pulse;
    if (pulse_en_r[1] && oe_nxt[PIN_REACT])
      out_nxt[PIN_REACT] = i_reactive_energy_pulse;
    if (pulse_en_r[2] && oe_nxt[PIN_AUX_X])
      out_nxt[PIN_AUX_X] = i_aux_x_pulse;
    if (pulse_en_r[3] && oe_nxt[PIN_AUX_Y])
      out_nxt[PIN_AUX_Y] = i_aux_y_pulse;
    if (i_eeprom_route_en)
    begin
      out_nxt[PIN_EE_SCK] = i_ee_sck_out;
      oe_nxt[PIN_EE_SCK] = i_ee_sck_oe;
      out_nxt[PIN_EE_SDA] = i_ee_sda_out;
      oe_nxt[PIN_EE_SDA] = i_ee_sda_oe;
    end
    if (i_optical_uart_en)
    begin
      out_nxt[PIN_OPTICAL_TX_PIN] = i_optical_tx_pin;
      oe_nxt[PIN_OPTICAL_TX_PIN] = 1'b1;
      oe_nxt[PIN_OPTICAL_RX_PIN] = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      out_r <= '0;
      oe_r <= '0;
      lcd_r <= '0;
      rx_r <= 1'b0;
      sda_r <= 1'b0;
    end
    else
    begin
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      lcd_r <= pin_lcd;
      rx_r <= pin_sync_r[PIN_OPTICAL_RX_PIN];
      sda_r <= pin_sync_r[PIN_EE_SDA];
    end
  end

  assign o_pin_out = out_r;
  assign o_pin_oe = oe_r;
  assign o_pin_lcd_sel = lcd_r;
  assign o_optical_rx_pin = rx_r;
  assign o_ee_sda_in = sda_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Resource routing; pin selectors apply only while the pin serves as general I/O, the receive selector only with the UART on
  route_if rif ();
  logic [NUM_SEL_PINS-1:0] sel_ok;

  for (genvar g = 0; g < NUM_SEL_PINS; g++)
  begin : g_route
    assign sel_ok[g] = !pin_lcd[g]
                       && !(i_optical_uart_en && (g == PIN_OPTICAL_TX_PIN || g == PIN_OPTICAL_RX_PIN))
                       && !(i_eeprom_route_en && (g == PIN_EE_SCK || g == PIN_EE_SDA));
    assign rif.level[g] = pin_sync_r[g];
    assign rif.sel[g] = sel_ok[g] ? rsel_r[g] : SEL_W'(RES_NONE);
  end
  assign rif.level[SRX_IDX] = pin_sync_r[PIN_OPTICAL_RX_PIN];
  assign rif.sel[SRX_IDX] = i_optical_uart_en ? srx_sel_r : SEL_W'(RES_NONE);

  resource_router u_router (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .rif(rif.rtr)
  );

  assign o_counter0_clock_in = rif.cnt0;
  assign o_counter1_clock_in = rif.cnt1;
  assign o_high_prio_pin_irq = rif.irq_hi;
  assign o_low_prio_pin_irq = rif.irq_lo;

  ////////////////////////////////////////////////////////////////////////////////
  // Read-back, registered; ports read the synchronised pad levels
  logic [7:0] sfr_nxt;
  logic [7:0] io_nxt;
  logic [7:0] sfr_r;
  logic [7:0] io_r;

  always_comb
  begin
    sfr_nxt = 8'h00;
    for (int k = 0; k < PORT_REGS; k++)
      if (i_sfr_addr == SFR_PORT_ADDR[k])
        sfr_nxt = pin_sync_r[8 * k +: 8];
    for (int k = 0; k < DIR_REGS; k++)
      if (i_sfr_addr == SFR_DIR_ADDR[k])
        sfr_nxt = dir_r[k];
  end

  always_comb
  begin
    io_nxt = 8'h00;
    if (i_ioram_addr >= SEG_BASE && i_ioram_addr <= SEG_LAST)
      io_nxt = {seg_r[{seg_byte, 1'b1}], seg_r[{seg_byte, 1'b0}]};
    else if (i_ioram_addr >= RSEL_BASE && i_ioram_addr <= RSEL_LAST)
      io_nxt = {1'b0, rsel_r[{rsel_byte, 1'b1}], 1'b0, rsel_r[{rsel_byte, 1'b0}]};
    else if (i_ioram_addr == SRX_RSEL_ADDR)
      io_nxt = {5'h00, srx_sel_r};
    else if (ddat_ofs < 16'(DED_PINS))
      io_nxt[DED_DATA_BIT] = ded_dat_r[ddat_ofs[1:0]];
    else if (ddir_ofs < 16'(DED_PINS))
      io_nxt[DED_DIR_BIT] = ded_dir_r[ddir_ofs[1:0]];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      sfr_r <= 8'h00;
      io_r <= 8'h00;
    end
    else
    begin
      sfr_r <= sfr_nxt;
      io_r <= io_nxt;
    end
  end

  assign o_sfr_rdata = sfr_r;
  assign o_ioram_rdata = io_r;

  ////////////////////////////////////////////////////////////////////////////////
  property p_dir_out;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_sfr_we && i_sfr_addr == SFR_DIR_ADDR[1] && i_sfr_wdata[2])
      ##1 (!i_pin_function_map[10 + SEG_OFS] && !dir_hit[1]) |=> o_pin_oe[10];
  endproperty
  a_dir_out: assert property (p_dir_out) else $error("pin 10 not driven after dir set");

  property p_cell43;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_ioram_we && i_ioram_addr == CELL43_ADDR)
      |=> pin_dat[43] == $past(i_ioram_wdata[HI_LSB + CELL_DATA_BIT]);
  endproperty
  a_cell43: assert property (p_cell43) else $error("pin 43 data not from cell byte");

  property p_act_pulse;
    @(posedge i_clk) disable iff (i_sys_rst)
      (pulse_en_r[0] && pin_dir[PIN_ACT] && !pin_lcd[PIN_ACT])
      |=> o_pin_out[PIN_ACT] == $past(i_active_energy_pulse) && o_pin_oe[PIN_ACT];
  endproperty
  a_act_pulse: assert property (p_act_pulse) else $error("active pulse not on pin 6");

  property p_button_in;
    @(posedge i_clk) disable iff (i_sys_rst)
      ##1 !o_pin_oe[PIN_BUTTON];
  endproperty
  a_button_in: assert property (p_button_in) else $error("button pin driven");

  property p_reset_clear;
    @(posedge i_clk) disable iff (1'b0)
      i_sys_rst |=> o_pin_oe == '0 && !o_high_prio_pin_irq && pulse_en_r == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not cleared by reset");

endmodule

// File: logic/pin_router_pkg.sv
// Shared constants and types for the pin function and resource router
package pin_router_pkg;

  // Pin population
  localparam int NUM_PINS = 59;
  localparam int NUM_SEG = 76;
  localparam int NUM_SEL_PINS = 12;
  localparam int NUM_RES = 13;
  localparam int SRX_IDX = 12;
  localparam int SEL_W = 3;
  localparam int NIB_W = 4;
  localparam int PORT_REGS = 4;
  localparam int DIR_REGS = 3;
  localparam int DED_PINS = 3;

  // Pin ranges and fixed pin numbers
  localparam int SFR_DIR_PINS = 24;
  localparam int SFR_DATA_PINS = 32;
  localparam int CELL_DATA_FIRST = 36;
  localparam int MULTI_FIRST = 4;
  localparam int DED_FIRST = 56;
  localparam int SEG_OFS = 20;
  localparam int PIN_BUTTON = 0;
  localparam int PIN_OPTICAL_TX_PIN = 1;
  localparam int PIN_OPTICAL_RX_PIN = 2;
  localparam int PIN_EE_SCK = 4;
  localparam int PIN_EE_SDA = 5;
  localparam int PIN_ACT = 6;
  localparam int PIN_REACT = 7;
  localparam int PIN_AUX_X = 8;
  localparam int PIN_AUX_Y = 9;

  // Field positions inside I/O RAM bytes
  localparam int CELL_DATA_BIT = 0;
  localparam int CELL_DIR_BIT = 3;
  localparam int DED_DATA_BIT = 4;
  localparam int DED_DIR_BIT = 7;
  localparam int HI_LSB = 4;

  // SFR addresses
  localparam logic [7:0] SFR_PORT_ADDR [PORT_REGS] = '{8'h80, 8'h90, 8'hA0, 8'hB0};
  localparam logic [7:0] SFR_DIR_ADDR [DIR_REGS] = '{8'hA2, 8'h91, 8'hA1};

  // I/O RAM addresses
  localparam logic [15:0] RSEL_BASE = 16'h2009;
  localparam logic [15:0] RSEL_LAST = 16'h200E;
  localparam logic [15:0] SRX_RSEL_ADDR = 16'h200F;
  localparam logic [15:0] SEG_BASE = 16'h2026;
  localparam logic [15:0] SEG_LAST = 16'h204B;
  localparam logic [15:0] DED_DATA_BASE = 16'h2050;
  localparam logic [15:0] DED_DIR_BASE = 16'h2054;

  // Resource selector codes
  typedef enum logic [SEL_W-1:0] {
    RES_NONE,
    RES_RSVD,
    RES_CNT0,
    RES_CNT1,
    RES_HI_RISE,
    RES_LO_RISE,
    RES_HI_FALL,
    RES_LO_FALL
  } res_code_type;

endpackage

// File: logic/route_if.sv
// Carrier between pin logic and the resource router
`timescale 1ns/100ps
interface route_if
  import pin_router_pkg::*;
#(
  parameter int N = NUM_RES
);
  logic [N-1:0] level;
  logic [N-1:0][SEL_W-1:0] sel;
  logic cnt0;
  logic cnt1;
  logic irq_hi;
  logic irq_lo;

  modport src (output level, output sel, input cnt0, input cnt1, input irq_hi, input irq_lo);
  modport rtr (input level, input sel, output cnt0, output cnt1, output irq_hi, output irq_lo);
endinterface

// File: logic/resource_router.sv
// Edge detection and ORed routing of pin levels to counters and interrupts
`timescale 1ns/100ps
module resource_router
  import pin_router_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Synchronised levels and selectors in, strobes out
  route_if.rtr rif
);

  logic [NUM_RES-1:0] prev_r;
  logic [NUM_RES-1:0] rise;
  logic [NUM_RES-1:0] fall;
  logic cnt0_r;
  logic cnt1_r;
  logic hi_r;
  logic lo_r;
  logic cnt0_nxt;
  logic cnt1_nxt;
  logic hi_nxt;
  logic lo_nxt;

  assign rise = rif.level & ~prev_r;
  assign fall = ~rif.level & prev_r;

  always_comb
  begin
    cnt0_nxt = 1'b0;
    cnt1_nxt = 1'b0;
    hi_nxt = 1'b0;
    lo_nxt = 1'b0;
    for (int k = 0; k < NUM_RES; k++)
    begin
      case (res_code_type'(rif.sel[k]))
        RES_CNT0: cnt0_nxt = cnt0_nxt | rise[k];
        RES_CNT1: cnt1_nxt = cnt1_nxt | rise[k];
        RES_HI_RISE: hi_nxt = hi_nxt | rise[k];
        RES_LO_RISE: lo_nxt = lo_nxt | rise[k];
        RES_HI_FALL: hi_nxt = hi_nxt | fall[k];
        RES_LO_FALL: lo_nxt = lo_nxt | fall[k];
        default: ; // Reserved code routes nothing
      endcase
    end
  end

  // One strobe per edge, since prev_r follows the level every cycle
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      prev_r <= '0;
      cnt0_r <= 1'b0;
      cnt1_r <= 1'b0;
      hi_r <= 1'b0;
      lo_r <= 1'b0;
    end
    else
    begin
      prev_r <= rif.level;
      cnt0_r <= cnt0_nxt;
      cnt1_r <= cnt1_nxt;
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
    end
  end

  assign rif.cnt0 = cnt0_r;
  assign rif.cnt1 = cnt1_r;
  assign rif.irq_hi = hi_r;
  assign rif.irq_lo = lo_r;

  //////////////////////////////////////////////////////////////////////////////
  property p_hi_rise;
    @(posedge i_clk) disable iff (i_sys_rst)
      (rif.sel[3] == SEL_W'(RES_HI_RISE) && rif.level[3] && !prev_r[3]) |=> rif.irq_hi;
  endproperty
  a_hi_rise: assert property (p_hi_rise) else $error("rising edge missed high irq");

  property p_lo_fall;
    @(posedge i_clk) disable iff (i_sys_rst)
      (rif.sel[3] == SEL_W'(RES_LO_FALL) && !rif.level[3] && $past(rif.level[3]))
      |=> rif.irq_lo;
  endproperty
  a_lo_fall: assert property (p_lo_fall) else $error("falling edge missed low irq");

  property p_or_cnt1;
    @(posedge i_clk) disable iff (i_sys_rst)
      (rif.sel[SRX_IDX] == SEL_W'(RES_CNT1) && rise[SRX_IDX]) |=> rif.cnt1 && !rif.cnt0;
  endproperty
  a_or_cnt1: assert property (p_or_cnt1) else $error("counter 1 strobe wrong");

  property p_no_edge;
    @(posedge i_clk) disable iff (i_sys_rst)
      (rif.level == prev_r) |=> !(rif.cnt0 || rif.cnt1 || rif.irq_hi || rif.irq_lo);
  endproperty
  a_no_edge: assert property (p_no_edge) else $error("strobe without an edge");

endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the pin function and resource router
`timescale 1ns/100ps
module tb_top
  import pin_router_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [NUM_PINS-1:0] i_pin_in = '0;
  logic [NUM_PINS-1:0] o_pin_out, o_pin_oe, o_pin_lcd_sel;
  logic i_sfr_we = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic [7:0] o_sfr_rdata, o_ioram_rdata;
  logic i_ioram_we = 1'b0;
  logic [15:0] i_ioram_addr = 16'h0000;
  logic [7:0] i_ioram_wdata = 8'h00;
  logic [NUM_SEG-1:0] i_pin_function_map = '0;
  logic act_en = 1'b0, react_en = 1'b0, ax_en = 1'b0, ay_en = 1'b0;
  logic uart_en = 1'b0, ee_en = 1'b0;
  logic act_p = 1'b0, react_p = 1'b0, ax_p = 1'b0, ay_p = 1'b0, tx = 1'b0;
  logic sck = 1'b0, sck_oe = 1'b0, sda = 1'b0, sda_oe = 1'b0;
  logic o_optical_rx_pin, o_ee_sda_in;
  logic o_counter0_clock_in, o_counter1_clock_in, o_high_prio_pin_irq, o_low_prio_pin_irq;
  int fail_count = 0;
  int tests_run = 0;
  int n0, n1, nh, nl;

  pin_function_resource_router uut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pin_in(i_pin_in),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pin_lcd_sel(o_pin_lcd_sel),
    .i_sfr_we(i_sfr_we), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .i_ioram_we(i_ioram_we), .i_ioram_addr(i_ioram_addr),
    .i_ioram_wdata(i_ioram_wdata), .o_ioram_rdata(o_ioram_rdata),
    .i_pin_function_map(i_pin_function_map), .i_active_pulse_route_en(act_en),
    .i_reactive_pulse_route_en(react_en), .i_aux_x_route_en(ax_en),
    .i_aux_y_route_en(ay_en), .i_optical_uart_en(uart_en), .i_eeprom_route_en(ee_en),
    .i_active_energy_pulse(act_p), .i_reactive_energy_pulse(react_p),
    .i_aux_x_pulse(ax_p), .i_aux_y_pulse(ay_p), .i_optical_tx_pin(tx),
    .o_optical_rx_pin(o_optical_rx_pin), .i_ee_sck_out(sck), .i_ee_sck_oe(sck_oe),
    .i_ee_sda_out(sda), .i_ee_sda_oe(sda_oe), .o_ee_sda_in(o_ee_sda_in),
    .o_counter0_clock_in(o_counter0_clock_in), .o_counter1_clock_in(o_counter1_clock_in),
    .o_high_prio_pin_irq(o_high_prio_pin_irq), .o_low_prio_pin_irq(o_low_prio_pin_irq)
  );

  always #20 i_clk = ~i_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // Writes last one cycle; the strobe then stays low across one edge before the next write
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_we = 1'b1;
    i_sfr_addr = a;
    i_sfr_wdata = d;
    cyc(1);
    i_sfr_we = 1'b0;
    cyc(1);
  endtask

  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    i_ioram_we = 1'b1;
    i_ioram_addr = a;
    i_ioram_wdata = d;
    cyc(1);
    i_ioram_we = 1'b0;
    cyc(1);
  endtask

  // Strobes are single-cycle, so every falling edge sees each one once
  task automatic count(input int n);
    repeat (n)
    begin
      cyc(1);
      n0 += int'(o_counter0_clock_in === 1'b1);
      n1 += int'(o_counter1_clock_in === 1'b1);
      nh += int'(o_high_prio_pin_irq === 1'b1);
      nl += int'(o_low_prio_pin_irq === 1'b1);
    end
  endtask

  task automatic chk_counts(input int e0, input int e1, input int eh, input int el);
    chk("cnt0", 8'(e0), 8'(n0));
    chk("cnt1", 8'(e1), 8'(n1));
    chk("irq_hi", 8'(eh), 8'(nh));
    chk("irq_lo", 8'(el), 8'(nl));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("oe_reset", 8'h01, {7'h00, o_pin_oe === '0});
    chk("out_reset", 8'h01, {7'h00, o_pin_out === '0});
  endtask

  task automatic t_sfr();
    sfr_wr(8'h91, 8'h05);
    sfr_wr(8'h90, 8'h04);
    sfr_wr(8'hA2, 8'h41);
    i_sfr_addr = 8'h91;
    cyc(2);
    chk("dir_b_read", 8'h05, o_sfr_rdata);
    chk("oe10", 8'h01, {7'h00, o_pin_oe[10]});
    chk("out10", 8'h01, {7'h00, o_pin_out[10]});
    chk("oe0_button", 8'h00, {7'h00, o_pin_oe[PIN_BUTTON]});
    chk("oe9_input", 8'h00, {7'h00, o_pin_oe[9]});
  endtask

  task automatic t_cells();
    // Pin 43 sits in the upper nibble, pin 42 in the lower one of the same byte
    io_wr(16'h2045, 8'h98);
    io_wr(16'h2050, 8'h10);
    io_wr(16'h2054, 8'h80);
    i_ioram_addr = 16'h2045;
    cyc(2);
    chk("cell_read", 8'h98, o_ioram_rdata);
    chk("out43", 8'h01, {7'h00, o_pin_out[43]});
    chk("oe43", 8'h01, {7'h00, o_pin_oe[43]});
    chk("oe42", 8'h01, {7'h00, o_pin_oe[42]});
    chk("out42", 8'h00, {7'h00, o_pin_out[42]});
    chk("out56", 8'h01, {7'h00, o_pin_out[DED_FIRST]});
    chk("oe56", 8'h01, {7'h00, o_pin_oe[DED_FIRST]});
    // Set pin 42 data through the segment byte while keeping the pin 43 nibble
    io_wr(16'h2045, o_ioram_rdata | 8'h01);
    chk("rmw_out42", 8'h01, {7'h00, o_pin_out[42]});
    chk("rmw_out43", 8'h01, {7'h00, o_pin_out[43]});
    i_pin_function_map[43 + SEG_OFS] = 1'b1;
    cyc(3);
    chk("lcd43", 8'h01, {7'h00, o_pin_lcd_sel[43]});
    chk("lcd42", 8'h00, {7'h00, o_pin_lcd_sel[42]});
  endtask

  task automatic t_pulses();
    // Pins 6, 7, 8 and 9 become outputs with data 0, so only a pulse can raise them
    sfr_wr(8'hA2, 8'hC1);
    sfr_wr(8'h91, 8'h07);
    act_en = 1'b1;
    react_en = 1'b1;
    ax_en = 1'b1;
    ay_en = 1'b1;
    act_p = 1'b1;
    react_p = 1'b1;
    ax_p = 1'b1;
    ay_p = 1'b1;
    cyc(3);
    chk("act_on", 8'h01, {7'h00, o_pin_out[PIN_ACT]});
    chk("react_on", 8'h01, {7'h00, o_pin_out[PIN_REACT]});
    chk("aux_x_on", 8'h01, {7'h00, o_pin_out[PIN_AUX_X]});
    chk("aux_y_on", 8'h01, {7'h00, o_pin_out[PIN_AUX_Y]});
    act_p = 1'b0;
    react_p = 1'b0;
    ax_p = 1'b0;
    ay_p = 1'b0;
    cyc(3);
    chk("act_off", 8'h00, {7'h00, o_pin_out[PIN_ACT]});
    chk("react_off", 8'h00, {7'h00, o_pin_out[PIN_REACT]});
    chk("aux_x_off", 8'h00, {7'h00, o_pin_out[PIN_AUX_X]});
    chk("aux_y_off", 8'h00, {7'h00, o_pin_out[PIN_AUX_Y]});
  endtask

  task automatic t_codes();
    res_code_type c;
    for (int k = 0; k < 8; k++)
    begin
      c = res_code_type'(k);
      io_wr(16'h200A, {1'b0, c, 4'h0});
      cyc(2);
      {n0, n1, nh, nl} = '0;
      i_pin_in[3] = 1'b1;
      count(8);
      i_pin_in[3] = 1'b0;
      count(8);
      chk_counts(int'(c == RES_CNT0), int'(c == RES_CNT1),
        int'(c == RES_HI_RISE || c == RES_HI_FALL),
        int'(c == RES_LO_RISE || c == RES_LO_FALL));
    end
  endtask

  task automatic t_or();
    // Pin 10 is an output here, yet its selector still tracks the pad
    io_wr(16'h200A, 8'h40);
    io_wr(16'h200E, 8'h04);
    cyc(2);
    {n0, n1, nh, nl} = '0;
    i_pin_in[10] = 1'b1;
    count(6);
    i_pin_in[3] = 1'b1;
    count(6);
    chk_counts(0, 0, 2, 0);
    i_pin_in[3] = 1'b0;
    i_pin_in[10] = 1'b0;
    cyc(4);
  endtask

  task automatic t_owners();
    uart_en = 1'b1;
    ee_en = 1'b1;
    tx = 1'b1;
    sck = 1'b1;
    sck_oe = 1'b1;
    sda = 1'b1;
    sda_oe = 1'b1;
    i_pin_in[PIN_EE_SDA] = 1'b1;
    io_wr(16'h200F, 8'h03);
    cyc(4);
    chk("ee_sda", 8'h01, {7'h00, o_pin_out[PIN_EE_SDA] & o_pin_oe[PIN_EE_SDA]});
    chk("optical_tx_pin", 8'h01, {7'h00, o_pin_out[PIN_OPTICAL_TX_PIN]});
    chk("ee_sck", 8'h01, {7'h00, o_pin_out[PIN_EE_SCK]});
    chk("ee_sck_oe", 8'h01, {7'h00, o_pin_oe[PIN_EE_SCK]});
    chk("ee_sda_in", 8'h01, {7'h00, o_ee_sda_in});
    {n0, n1, nh, nl} = '0;
    i_pin_in[PIN_OPTICAL_RX_PIN] = 1'b1;
    count(6);
    chk("optical_rx_pin", 8'h01, {7'h00, o_optical_rx_pin});
    chk_counts(0, 1, 0, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(10);
    i_sys_rst = 1'b0;
    t_reset();
    t_sfr();
    t_cells();
    t_pulses();
    t_codes();
    t_or();
    t_owners();
    conclude();
  end

  // The whole run needs well under a thousand cycles
  initial
  begin
    #(40 * 5000);
    fail_count++;
    conclude();
  end
endmodule
